// [src/arrow_pair_fault_monitor.sv]
// arrow channel-pair fault checks, event log, sequence log and serial dump
// assumes field inputs already qualified on/off and synchronous to CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module arrow_pair_fault_monitor
   import arrow_mon_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS,
   parameter int BAUD_CYC  = BAUD_DIV
) (
   input  wire logic                 CORE_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 CLK_EN,
   input  wire logic [NPAIR-1:0]     PAIR_ENABLE,
   input  wire logic [NPAIR-1:0]     PHASE_SELECT,
   input  wire logic                 ALTERNATE_PAIR_ASSIGNMENT_MODE,
   input  wire logic [NPAIR-1:0]     RED_TURN_ARROW,
   input  wire logic [NPAIR-1:0]     STEADY_YELLOW_TURN_ARROW,
   input  wire logic [NPAIR-1:0]     FLASHING_TURN_ARROW,
   input  wire logic [NPAIR-1:0]     GREEN_TURN_ARROW,
   input  wire logic [NPAIR-1:0]     GREEN_TURN_ARROW_ALT,
   input  wire logic [NCH-1:0]       CH_GREEN,
   input  wire logic [NCH-1:0]       CH_YELLOW,
   input  wire logic [NCH-1:0]       CH_RED,
   input  wire logic                 RED_ENABLE,
   input  wire logic [NPAIR*NCH-1:0] PERM_CONFLICT_MASK,
   input  wire logic [NPAIR*NCH-1:0] PROT_CONFLICT_MASK,
   input  wire logic                 NORMAL_CONFLICT,
   input  wire logic                 FLASH_RATE_EN_N,
   input  wire logic                 FRONT_RESET,
   input  wire logic                 REMOTE_RESET,
   input  wire logic                 CONFIG_CHANGE,
   input  wire logic                 AC_LINE_EVENT,
   input  wire logic [8*NPAIR-1:0]   RMS_LEVEL,
   input  wire logic                 RX_DATA,
   input  wire logic                 DTR,
   input  wire logic                 CTS,
   output logic                      TX_DATA,
   output logic                      DCD,
   output logic                      DSR,
   output logic                      RTS,
   output logic                      FAULT_FLASH,
   output logic [NPAIR-1:0]          CONFLICT_FAULT,
   output logic [NPAIR-1:0]          FLASH_RATE_FAULT,
   output logic [NPAIR-1:0]          RED_FAIL_FAULT,
   output logic [NPAIR-1:0]          DUAL_FAULT,
   output logic [NPAIR-1:0]          CLEARANCE_FAULT
);
   typedef struct packed {
      logic [15:0]                       ms_div;
      logic [31:0]                       ms_time;
      logic [5:0]                        seq_div;
      logic [NPAIR-1:0][10:0]            fcnt;
      logic [NPAIR-1:0][11:0]            ccnt;
      logic [NPAIR-1:0]                  crun;
      logic [NPAIR-1:0]                  perm;
      logic [NPAIR-1:0]                  ga;
      logic [NPAIR-1:0]                  flashing_turn_arrow;
      logic [NPAIR-1:0]                  conf;
      logic [NPAIR-1:0]                  flash;
      logic [NPAIR-1:0]                  redf;
      logic [NPAIR-1:0]                  dual;
      logic [NPAIR-1:0]                  clr;
      logic                              norm;
      logic [NEVT-1:0]                   pend;
      logic [3:0]                        ewp;
      evt_rec_t [EVT_DEPTH-1:0]          elog;
      logic [SEQ_DEPTH-1:0][SEQ_W-1:0]   slog;
      logic [5:0]                        swp;
      logic                              frozen;
      logic                              rdy;
      logic                              dtr;
      dump_t                             dst;
      logic [5:0]                        didx;
      logic [3:0]                        dbyte;
      logic                              tvalid;
      logic [7:0]                        tdata;
   } st_t;

   st_t                     q, d;
   ser_if                   tx ();
   logic [NPAIR-1:0]        en, ga, conf_det, flash_det, redf_det, dual_det;
   logic [4*NPAIR-1:0]      ind_all;
   logic [NCH-1:0]          act;
   logic                    tick, rst_req;

   assign rst_req = FRONT_RESET | REMOTE_RESET;
   assign tick    = (q.ms_div == 16'(MS_CYCLES - 1));
   assign act     = CH_GREEN | CH_YELLOW;
   assign en      = PAIR_ENABLE & PHASE_SELECT;
   assign ga      = ALTERNATE_PAIR_ASSIGNMENT_MODE ? GREEN_TURN_ARROW_ALT : GREEN_TURN_ARROW;

   genvar gp;
   generate
      for (gp = 0; gp < NPAIR; gp++) begin : g_pair
         logic [3:0]     ind;
         logic [NCH-1:0] mask;
         assign ind  = {RED_TURN_ARROW[gp], STEADY_YELLOW_TURN_ARROW[gp],
                        FLASHING_TURN_ARROW[gp], ga[gp]};
         assign ind_all[gp*4 +: 4] = ind;
         assign mask = q.perm[gp] ? PERM_CONFLICT_MASK[gp*NCH +: NCH]
                                  : PROT_CONFLICT_MASK[gp*NCH +: NCH];
         assign conf_det[gp]  = en[gp] & STEADY_YELLOW_TURN_ARROW[gp] & (|(act & mask));
         assign flash_det[gp] = en[gp] & ~FLASH_RATE_EN_N & FLASHING_TURN_ARROW[gp] & tick
                                & (q.fcnt[gp] == 11'(FLASH_LIMIT_MS - 1));
         assign redf_det[gp]  = en[gp] & RED_ENABLE & ~(|ind);
         assign dual_det[gp]  = en[gp] & RED_ENABLE & ($countones(ind) >= 2);
      end
   endgenerate

   always_comb begin
      logic [NPAIR-1:0]         clr_det;
      logic [NPAIR-1:0]         rmask;
      logic [NEVT-1:0][NPAIR-1:0] kv;
      logic [NEVT-1:0]          newev;
      logic [EVT_W-1:0]         rec;
      logic                     found;
      int                       sidx;
      d       = q;
      kv      = '0;
      newev   = '0;
      clr_det = '0;
      rmask   = {NPAIR{rst_req}};
      found   = 1'b0;
      rec     = '0;
      sidx    = 0;
      d.rdy   = 1'b1;
      d.dtr   = DTR;
      d.ms_div = tick ? 16'h0000 : q.ms_div + 16'h0001;
      if (tick) begin
         d.ms_time = q.ms_time + 32'h00000001;
      end
      for (int p = 0; p < NPAIR; p++) begin
         d.ga[p]  = ga[p];
         d.flashing_turn_arrow[p] = FLASHING_TURN_ARROW[p];
         if (FLASHING_TURN_ARROW[p]) begin
            d.perm[p] = 1'b1;
         end else if (ga[p]) begin
            d.perm[p] = 1'b0;
         end
         if (!FLASHING_TURN_ARROW[p] || !en[p]) begin
            d.fcnt[p] = 11'h000;
         end else if (tick && q.fcnt[p] != 11'(FLASH_LIMIT_MS - 1)) begin
            d.fcnt[p] = q.fcnt[p] + 11'h001;
         end
         if (en[p] && ((q.ga[p] && !ga[p]) || (q.flashing_turn_arrow[p] && !FLASHING_TURN_ARROW[p]))) begin
            d.crun[p] = 1'b1;
            d.ccnt[p] = 12'h000;
         end else if (q.crun[p]) begin
            if (!STEADY_YELLOW_TURN_ARROW[p]) begin
               clr_det[p] = 1'b1;
               d.crun[p]  = 1'b0;
            end else if (tick) begin
               d.ccnt[p] = q.ccnt[p] + 12'h001;
               if (q.ccnt[p] == 12'(CLEAR_MIN_MS - 1)) begin
                  d.crun[p] = 1'b0;
               end
            end
         end
      end
      d.conf  = (q.conf & ~rmask) | conf_det;
      d.flash = (q.flash & ~rmask) | flash_det;
      d.redf  = (q.redf & ~rmask) | redf_det;
      d.dual  = (q.dual & ~rmask) | dual_det;
      d.clr   = (q.clr & ~rmask) | clr_det;
      d.norm  = (q.norm & ~rst_req) | NORMAL_CONFLICT;
      kv[4:0] = {d.clr, d.dual, d.redf, d.flash, d.conf};
      newev   = {AC_LINE_EVENT,
                 rst_req & (|{q.conf, q.flash, q.redf, q.dual, q.clr, q.norm}),
                 CONFIG_CHANGE, rst_req,
                 |(clr_det & ~q.clr), |(dual_det & ~q.dual), |(redf_det & ~q.redf),
                 |(flash_det & ~q.flash),
                 |(conf_det & ~q.conf) | (NORMAL_CONFLICT & ~q.norm)};
      for (int k = 0; k < NEVT; k++) begin
         if (q.pend[k] && !found) begin
            found = 1'b1;
            rec   = {act, RMS_LEVEL, ind_all, kv[k],
                     4'(k + 1), q.ms_time};
            d.pend[k] = 1'b0;
         end
      end
      if (found) begin
         d.elog[q.ewp] = rec;
         d.ewp = (q.ewp == 4'(EVT_DEPTH - 1)) ? 4'h0 : q.ewp + 4'h1;
      end
      d.pend = d.pend | newev;
      if (|newev[4:0]) begin
         d.frozen = 1'b1;
      end else if (rst_req) begin
         d.frozen = 1'b0;
      end
      if (tick) begin
         d.seq_div = (q.seq_div == 6'(SEQ_SAMPLE_MS - 1)) ? 6'h00 : q.seq_div + 6'h01;
         if (q.seq_div == 6'(SEQ_SAMPLE_MS - 1) && !q.frozen) begin
            d.slog[q.swp] = {{(SEQ_W - 3*NCH - 1){1'b0}}, CH_GREEN, CH_YELLOW, CH_RED,
                             RED_ENABLE};
            d.swp = (q.swp == 6'(SEQ_DEPTH - 1)) ? 6'h00 : q.swp + 6'h01;
         end
      end
      if (q.tvalid && tx.ready) begin
         d.tvalid = 1'b0;
      end
      sidx = (int'(q.swp) + int'(q.didx)) % SEQ_DEPTH;
      case (q.dst)
         D_IDLE: begin
            if (DTR && !q.dtr && CTS) begin
               d.dst   = D_EVT;
               d.didx  = 6'h00;
               d.dbyte = 4'h0;
            end
         end
         D_EVT: begin
            if (!q.tvalid && CTS) begin
               rec      = q.elog[q.didx];
               d.tvalid = 1'b1;
               d.tdata  = rec[q.dbyte*8 +: 8];
               d.dbyte  = (q.dbyte == 4'(EVT_BYTES - 1)) ? 4'h0 : q.dbyte + 4'h1;
               if (q.dbyte == 4'(EVT_BYTES - 1)) begin
                  d.didx = (q.didx == 6'(EVT_DEPTH - 1)) ? 6'h00 : q.didx + 6'h01;
                  if (q.didx == 6'(EVT_DEPTH - 1)) begin
                     d.dst = D_SEQ;
                  end
               end
            end
         end
         D_SEQ: begin
            if (!q.tvalid && CTS) begin
               d.tvalid = 1'b1;
               d.tdata  = q.slog[sidx][q.dbyte*8 +: 8];
               d.dbyte  = (q.dbyte == 4'(SEQ_BYTES - 1)) ? 4'h0 : q.dbyte + 4'h1;
               if (q.dbyte == 4'(SEQ_BYTES - 1)) begin
                  d.didx = q.didx + 6'h01;
                  if (q.didx == 6'(SEQ_DEPTH - 1)) begin
                     d.dst = D_DONE;
                  end
               end
            end
         end
         D_DONE: begin
            if (!DTR && !q.tvalid && tx.ready) begin
               d.dst = D_IDLE;
            end
         end
         default: d.dst = D_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         q <= '0;
      end else if (CLK_EN) begin
         q <= d;
      end
   end

   assign tx.valid = q.tvalid;
   assign tx.data  = q.tdata;

   serial_tx #(
      .DIV (BAUD_CYC)
   ) u_tx (
      .clk   (CORE_CLK),
      .rst_n (RESET_N),
      .ce    (CLK_EN),
      .s     (tx),
      .txd   (TX_DATA)
   );

   assign DCD              = (q.dst != D_IDLE);
   assign DSR              = q.rdy;
   assign RTS              = q.rdy & ~q.tvalid;
   assign CONFLICT_FAULT   = q.conf;
   assign FLASH_RATE_FAULT = q.flash;
   assign RED_FAIL_FAULT   = q.redf;
   assign DUAL_FAULT       = q.dual;
   assign CLEARANCE_FAULT  = q.clr;
   assign FAULT_FLASH      = |{q.conf, q.flash, q.redf, q.dual, q.clr, q.norm};

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   property p_flash_trip;
      CLK_EN && flash_det[0] |=> FLASH_RATE_FAULT[0] && FAULT_FLASH;
   endproperty
   a_flash_trip: assert property (p_flash_trip) else $error("flash fault not raised");
   property p_flash_early;
      CLK_EN && q.fcnt[0] < 11'(FLASH_MIN_MS - 1) && !q.flash[0] |=> !q.flash[0];
   endproperty
   a_flash_early: assert property (p_flash_early) else $error("flash fault too soon");
   property p_flash_hold;
      q.flash[0] && !rst_req |=> q.flash[0];
   endproperty
   a_flash_hold: assert property (p_flash_hold) else $error("flash fault dropped");
   property p_flash_off;
      FLASH_RATE_EN_N && !q.flash[0] |=> !q.flash[0];
   endproperty
   a_flash_off: assert property (p_flash_off) else $error("flash fault while disabled");
   property p_red_fail;
      CLK_EN && en[1] && RED_ENABLE && RED_TURN_ARROW[1] == 1'b0 && ga[1] == 1'b0
      && !STEADY_YELLOW_TURN_ARROW[1] && !FLASHING_TURN_ARROW[1] |=> RED_FAIL_FAULT[1];
   endproperty
   a_red_fail: assert property (p_red_fail) else $error("red failure missed");
   property p_dual;
      CLK_EN && en[0] && RED_ENABLE && RED_TURN_ARROW[0] && ga[0] |=> DUAL_FAULT[0];
   endproperty
   a_dual: assert property (p_dual) else $error("dual indication missed");
   property p_disabled;
      !en[3] && !q.dual[3] && !q.redf[3] |=> !q.dual[3] && !q.redf[3];
   endproperty
   a_disabled: assert property (p_disabled) else $error("fault on disabled pair");
   property p_perm_ycc;
      CLK_EN && en[0] && q.perm[0] && STEADY_YELLOW_TURN_ARROW[0]
      && |(act & PERM_CONFLICT_MASK[NCH-1:0]) |=> CONFLICT_FAULT[0];
   endproperty
   a_perm_ycc: assert property (p_perm_ycc) else $error("yellow change conflict missed");
   property p_log_write;
      CLK_EN && |q.pend |=> q.ewp != $past(q.ewp);
   endproperty
   a_log_write: assert property (p_log_write) else $error("pending event not logged");
   property p_dump_start;
      CLK_EN && q.dst == D_IDLE && DTR && !q.dtr && CTS |=> DCD ##1 DCD;
   endproperty
   a_dump_start: assert property (p_dump_start) else $error("dump did not start");
endmodule : arrow_pair_fault_monitor
`default_nettype wire

// [include/arrow_mon_pkg.sv]
// constants, record layouts and encodings for the arrow-pair fault monitor
// assumes a 50 MHz core clock and qualified (on/off) field inputs
package arrow_mon_pkg;
   localparam int NPAIR          = 4;
   localparam int NCH            = 16;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int MS_NS          = 1000000;
   localparam int CYCLES_PER_MS  = MS_NS / CLK_PERIOD_NS;
   localparam int FLASH_MIN_MS   = 1400;
   localparam int FLASH_MAX_MS   = 1600;
   localparam int FLASH_LIMIT_MS = (FLASH_MIN_MS + FLASH_MAX_MS) / 2;
   localparam int CLEAR_MIN_MS   = 2700;
   localparam int EVT_DEPTH      = 9;
   localparam int NEVT           = 9;
   localparam int SEQ_SAMPLE_MS  = 50;
   localparam int SEQ_SPAN_MS    = 2000;
   localparam int SEQ_DEPTH      = SEQ_SPAN_MS / SEQ_SAMPLE_MS;
   localparam int SEQ_W          = 56;
   localparam int SEQ_BYTES      = SEQ_W / 8;
   localparam int BAUD           = 9600;
   localparam int BAUD_DIV       = 1000000000 / (CLK_PERIOD_NS * BAUD);

   typedef enum logic [3:0] {
      EV_NONE = 4'h0, EV_CONFLICT = 4'h1, EV_FLASH_RATE = 4'h2, EV_RED_FAIL = 4'h3,
      EV_DUAL = 4'h4, EV_CLEARANCE = 4'h5, EV_MON_RESET = 4'h6, EV_CONFIG = 4'h7,
      EV_PREV_FAULT = 4'h8, EV_AC_LINE = 4'h9
   } ev_t;

   typedef struct packed {
      logic [NCH-1:0]     chans;
      logic [8*NPAIR-1:0] rms;
      logic [4*NPAIR-1:0] states;
      logic [NPAIR-1:0]   pairs;
      logic [3:0]         kind;
      logic [31:0]        time_ms;
   } evt_rec_t;

   localparam int EVT_W     = $bits(evt_rec_t);
   localparam int EVT_BYTES = EVT_W / 8;

   typedef enum logic [1:0] {
      D_IDLE = 2'b00, D_EVT = 2'b01, D_SEQ = 2'b11, D_DONE = 2'b10
   } dump_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11, TX_STOP = 2'b10
   } tx_t;
endpackage : arrow_mon_pkg

// [include/ser_if.sv]
// byte handshake between the log dump logic and the serial transmitter
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface ser_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ser_if
`default_nettype wire

// [src/serial_tx.sv]
// 8N1 asynchronous transmitter for the log dump
// assumes a clock enable that freezes all state while low
`timescale 1ns/1ps
`default_nettype none
module serial_tx
   import arrow_mon_pkg::*;
#(
   parameter int DIV = BAUD_DIV
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   ser_if.snk        s,
   output logic      txd
);
   typedef struct packed {
      tx_t         st;
      logic [15:0] div;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic        txd;
   } tx_st_t;
   localparam tx_st_t TX_RST = '{st: TX_IDLE, div: 16'h0000, bitn: 3'h0, sh: 8'h00, txd: 1'b1};

   tx_st_t q, d;
   logic   bit_end;

   assign bit_end = (q.div == 16'(DIV - 1));
   assign s.ready = (q.st == TX_IDLE);
   assign txd     = q.txd;

   always_comb begin
      d = q;
      if (q.st != TX_IDLE) begin
         d.div = bit_end ? 16'h0000 : q.div + 16'h0001;
      end
      case (q.st)
         TX_IDLE: begin
            if (s.valid) begin
               d.sh  = s.data;
               d.st  = TX_START;
               d.txd = 1'b0;
               d.div = 16'h0000;
            end
         end
         TX_START: begin
            if (bit_end) begin
               d.st   = TX_DATA;
               d.txd  = q.sh[0];
               d.bitn = 3'h0;
            end
         end
         TX_DATA: begin
            if (bit_end) begin
               d.sh   = {1'b0, q.sh[7:1]};
               d.bitn = q.bitn + 3'h1;
               d.txd  = (q.bitn == 3'h7) ? 1'b1 : q.sh[1];
               if (q.bitn == 3'h7) begin
                  d.st = TX_STOP;
               end
            end
         end
         TX_STOP: begin
            if (bit_end) begin
               d.st = TX_IDLE;
            end
         end
         default: d = TX_RST;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= TX_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   sequence s_take;
      ce && s.valid && s.ready;
   endsequence
   sequence s_start_bit;
      !txd [*2];
   endsequence
   property p_frame_start;
      @(posedge clk) disable iff (!rst_n) s_take |=> s_start_bit;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("no start bit after byte taken");
   property p_idle_high;
      @(posedge clk) disable iff (!rst_n) (q.st == TX_IDLE) |-> txd;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not idle high");
endmodule : serial_tx
`default_nettype wire

// [dv/ser_ctl_model.sv]
// serial controller model: raises DTR, paces with CTS, counts received bytes
// assumes 8N1 framing at bc clock cycles per bit
`timescale 1ns/1ps
`default_nettype none
module ser_ctl_model #(
   parameter int BC = 4
) (
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic go,
   input  wire logic stall,
   output logic      dtr,
   output logic      cts,
   output logic      rxd,
   output int        nbytes,
   output int        nbad,
   output logic [7:0] last_byte
);
   logic [7:0] b;
   assign dtr = go;
   assign cts = ~stall;
   assign rxd = 1'b1;
   initial begin
      nbytes = 0;
      nbad = 0;
   end
   always begin
      @(negedge txd);
      repeat (BC / 2) @(posedge clk);
      repeat (8) begin
         repeat (BC) @(posedge clk);
         b = {txd, b[7:1]};
      end
      repeat (BC) @(posedge clk);
      if (txd !== 1'b1) nbad++;
      last_byte = b;
      nbytes++;
   end
endmodule : ser_ctl_model
`default_nettype wire

// [dv/arrow_pair_fault_monitor_tb.sv]
// self-checking bench for the arrow-pair fault monitor
// assumes ser_ctl_model on the serial side, 5-cycle ms and 4-cycle bits
`timescale 1ns/1ps
`default_nettype none
module arrow_pair_fault_monitor_tb;
   import arrow_mon_pkg::*;
   localparam int MSC = 5;
   logic        clk = 1'b0, rst_n = 1'b0, en = 1'b1, alt = 1'b0, ren = 1'b1;
   logic        nc = 1'b0, fen = 1'b0, frt = 1'b0, rmt = 1'b0, cfg = 1'b0;
   logic        acl = 1'b0, go = 1'b0, stall = 1'b0;
   logic [3:0]  pe = 4'h7, ps = 4'hf, ra = 4'h7, ya = 4'h0, fa = 4'h0;
   logic [3:0]  ga = 4'h0, gaa = 4'h0;
   logic [15:0] chg = 16'h0, chy = 16'h0, chr = 16'h0;
   logic [63:0] pm = 64'h20, pr = 64'h40;
   logic [31:0] rms = 32'h5a5a5a5a;
   wire logic   tx, dcd, dsr, rts, ff, dtr, cts, rxd;
   wire logic [3:0] cf, frf, rf, df, clf;
   wire logic [7:0] lb;
   int          failures = 0, samples_checked = 0, nb, nbad, n;
   always #10 clk = ~clk;
   arrow_pair_fault_monitor #(.MS_CYCLES(MSC), .BAUD_CYC(4)) dut (
      .CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .PAIR_ENABLE(pe),
      .PHASE_SELECT(ps), .ALTERNATE_PAIR_ASSIGNMENT_MODE(alt),
      .RED_TURN_ARROW(ra), .STEADY_YELLOW_TURN_ARROW(ya), .FLASHING_TURN_ARROW(fa),
      .GREEN_TURN_ARROW(ga), .GREEN_TURN_ARROW_ALT(gaa), .CH_GREEN(chg),
      .CH_YELLOW(chy), .CH_RED(chr), .RED_ENABLE(ren), .PERM_CONFLICT_MASK(pm),
      .PROT_CONFLICT_MASK(pr), .NORMAL_CONFLICT(nc), .FLASH_RATE_EN_N(fen),
      .FRONT_RESET(frt), .REMOTE_RESET(rmt), .CONFIG_CHANGE(cfg),
      .AC_LINE_EVENT(acl), .RMS_LEVEL(rms), .RX_DATA(rxd), .DTR(dtr), .CTS(cts),
      .TX_DATA(tx), .DCD(dcd), .DSR(dsr), .RTS(rts), .FAULT_FLASH(ff),
      .CONFLICT_FAULT(cf), .FLASH_RATE_FAULT(frf), .RED_FAIL_FAULT(rf),
      .DUAL_FAULT(df), .CLEARANCE_FAULT(clf));
   ser_ctl_model #(.BC(4)) ctl (.clk(clk), .txd(tx), .go(go), .stall(stall),
      .dtr(dtr), .cts(cts), .rxd(rxd), .nbytes(nb), .nbad(nbad), .last_byte(lb));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic clr(input logic rem);
      rmt = rem;
      frt = ~rem;
      tick(4);
      rmt = 1'b0;
      frt = 1'b0;
      tick(2);
      chk(ff, 1'b0);
   endtask : clr
   task automatic t_dual();
      ga[0] = 1'b1;
      alt = 1'b1;
      gaa[2] = 1'b1;
      tick(2);
      chk(df, 4'h4);
      alt = 1'b0;
      tick(2);
      chk(df, 4'h5);
      chk(ff, 1'b1);
      gaa = 4'h0;
      ga = 4'h0;
      clr(1'b0);
   endtask : t_dual
   task automatic t_red();
      ps[1] = 1'b0;
      ra[1] = 1'b0;
      tick(2);
      chk(rf, 4'h0);
      ps[1] = 1'b1;
      tick(2);
      chk(rf, 4'h2);
      ra[1] = 1'b1;
      nc = 1'b1;
      tick(2);
      chk(ff, 1'b1);
      nc = 1'b0;
      clr(1'b1);
   endtask : t_red
   task automatic flash_run(input int ms, input logic off, input logic e);
      fen = off;
      ra[0] = 1'b0;
      fa[0] = 1'b1;
      tick(ms * MSC);
      fa[0] = 1'b0;
      ra[0] = 1'b1;
      tick(20);
      chk(frf[0], e);
      fen = 1'b0;
      clr(1'b0);
   endtask : flash_run
   task automatic t_clear(input logic src, input int ms, input logic e);
      ra[0] = 1'b0;
      if (src) fa[0] = 1'b1;
      else ga[0] = 1'b1;
      tick(5);
      fa[0] = 1'b0;
      ga[0] = 1'b0;
      ya[0] = 1'b1;
      tick(ms * MSC);
      ya[0] = 1'b0;
      ra[0] = 1'b1;
      tick(3);
      chk(clf[0], e);
      clr(1'b0);
   endtask : t_clear
   task automatic t_conf(input int k);
      ra[0] = 1'b0;
      if (k[0]) ga[0] = 1'b1;
      else fa[0] = 1'b1;
      tick(5);
      ga[0] = 1'b0;
      fa[0] = 1'b0;
      ya[0] = 1'b1;
      chg = k[1] ? 16'h0040 : 16'h0020;
      tick(3);
      chk(cf[0], k[0] == k[1]);
      chg = 16'h0;
      ya[0] = 1'b0;
      ra[0] = 1'b1;
      clr(1'b1);
   endtask : t_conf
   task automatic t_dump();
      cfg = 1'b1;
      acl = 1'b1;
      chg = 16'h8000;
      tick(1);
      cfg = 1'b0;
      acl = 1'b0;
      go = 1'b1;
      tick(2);
      chk(dcd, 1'b1);
      chk(rts, 1'b0);
      go = 1'b0;
      tick(1000);
      stall = 1'b1;
      tick(100);
      n = nb;
      tick(400);
      chk(nb, n);
      chk(rts, 1'b1);
      stall = 1'b0;
      for (int i = 0; i < 30000 && dcd; i++) tick(1);
      chk(dcd, 1'b0);
      chk(nb, 9 * EVT_BYTES + SEQ_DEPTH * SEQ_BYTES);
      chk(nbad, 0);
      chk(lb, 8'h01);
      chg = 16'h0;
   endtask : t_dump
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      tick(11);
      chk(tx, 1'b1);
      tick(1);
      rst_n = 1'b1;
      tick(2);
      chk(dsr, 1'b1);
      chk(rts, 1'b1);
      t_dual();
      t_red();
      flash_run(1390, 1'b0, 1'b0);
      flash_run(1610, 1'b0, 1'b1);
      flash_run(1610, 1'b1, 1'b0);
      t_clear(1'b0, 2750, 1'b0);
      t_clear(1'b0, 50, 1'b1);
      t_clear(1'b1, 50, 1'b1);
      for (int k = 0; k < 4; k++) t_conf(k);
      t_dump();
      end_of_test();
   end
endmodule : arrow_pair_fault_monitor_tb
`default_nettype wire
